// ===== design/pmx_mii.v
// MII transmit clock, transmit sampling with fast-rate error substitution, fast-rate receive error and tri-state
`timescale 1ns/10ps
`include "pmx_mii_regs.vh"


// ****************************************
// Symbol FIFO
// ****************************************
module pmx_fifo #(
    parameter WIDTH = `PMX_SYM_W,
    parameter DEPTH = `PMX_FIFO_DEPTH,
    parameter AW    = 4
) (
    input  wire             mclk,
    input  wire             srst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      count;
    wire             push;
    wire             pop;
    reg  [AW:0]      next_count;

    assign push = in_valid && in_ready;
    // Load the output register when it is empty or being taken
    assign pop  = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            count    <= next_count;
            // Ready is registered from the next fill level
            in_ready <= (next_count < DEPTH[AW:0]);
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
                rd_ptr    <= rd_ptr + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // pmx_fifo

// ****************************************
// MII PHY-side path
// ****************************************
module pmx_mii #(
    parameter [`PMX_SYM_W-1:0] TEST_SYM = `PMX_TEST_SYM
) (
    input  wire                  mclk,
    input  wire                  srst,
    input  wire                  speed_100,
    input  wire                  err_code_test,
    output reg                   tx_clk,
    input  wire                  tx_en,
    input  wire                  tx_er,
    input  wire [`PMX_NIB_W-1:0] txd,
    output reg                   tx_active,
    output wire                  tx_fifo_ready,
    output wire [`PMX_SYM_W-1:0] line_sym,
    output wire                  line_valid,
    input  wire                  line_ready,
    input  wire [`PMX_NIB_W-1:0] rx_nib_in,
    input  wire                  rx_ssd_det,
    input  wire                  rx_esd_det,
    input  wire                  rx_sig_err,
    input  wire                  rx_false_carrier,
    input  wire                  rx_tristate_request,
    output reg                   rx_clk,
    output reg  [`PMX_NIB_W-1:0] rxd,
    output reg                   rx_dv,
    output reg                   rx_er,
    output reg                   rx_oe_n
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    reg  [6:0] sync_a;
    reg  [6:0] sync_b;
    wire       s_en;
    wire       s_er;
    wire [3:0] s_txd;
    wire       s_tri;

    always @(posedge mclk) begin
        if (srst) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {rx_tristate_request, tx_en, tx_er, txd};
            sync_b <= sync_a;
        end
    end

    assign s_tri = sync_b[6];
    assign s_en  = sync_b[5];
    assign s_er  = sync_b[4];
    assign s_txd = sync_b[3:0];

    // ****************************************
    // MII clock divider
    // ****************************************
    reg  [`PMX_DIV_W-1:0] div_cnt;
    wire [`PMX_DIV_W-1:0] half_lim;
    wire                  half_tick;
    wire                  rise_evt;
    wire                  fall_evt;

    // End counts are cut to the divider width on purpose; the slow half
    // period is what sets how wide the divider must be.
    localparam integer HALF_FAST_END = `PMX_HALF_FAST - 1;
    localparam integer HALF_SLOW_END = `PMX_HALF_SLOW - 1;

    assign half_lim  = speed_100 ? HALF_FAST_END[`PMX_DIV_W-1:0]
                                 : HALF_SLOW_END[`PMX_DIV_W-1:0];
    assign half_tick = (div_cnt >= half_lim);
    assign rise_evt  = half_tick && !tx_clk;
    assign fall_evt  = half_tick && tx_clk;

    always @(posedge mclk) begin
        if (srst) begin
            div_cnt <= {`PMX_DIV_W{1'b0}};
            tx_clk  <= 1'b0;
            rx_clk  <= 1'b0;
        end else if (half_tick) begin
            div_cnt <= {`PMX_DIV_W{1'b0}};
            tx_clk  <= !tx_clk;
            rx_clk  <= !tx_clk;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ****************************************
    // Transmit sampling and coding
    // ****************************************
    function [`PMX_SYM_W-1:0] enc4b5b;
        input [`PMX_NIB_W-1:0] nib;
        begin
            case (nib)
                4'h0:    enc4b5b = 5'h1E;
                4'h1:    enc4b5b = 5'h09;
                4'h2:    enc4b5b = 5'h14;
                4'h3:    enc4b5b = 5'h15;
                4'h4:    enc4b5b = 5'h0A;
                4'h5:    enc4b5b = 5'h0B;
                4'h6:    enc4b5b = 5'h0E;
                4'h7:    enc4b5b = 5'h0F;
                4'h8:    enc4b5b = 5'h12;
                4'h9:    enc4b5b = 5'h13;
                4'hA:    enc4b5b = 5'h16;
                4'hB:    enc4b5b = 5'h17;
                4'hC:    enc4b5b = 5'h1A;
                4'hD:    enc4b5b = 5'h1B;
                4'hE:    enc4b5b = 5'h1C;
                default: enc4b5b = 5'h1D;
            endcase
        end
    endfunction

    reg  [`PMX_SYM_W-1:0] next_sym;
    reg  [`PMX_SYM_W-1:0] wr_sym;
    reg                   wr_valid;
    wire                  fifo_in_ready;

    always @* begin
        next_sym = {1'b0, s_txd};
        if (speed_100) begin
            if (s_er) begin
                next_sym = err_code_test ? TEST_SYM : `PMX_HALT_SYM;
            end else begin
                next_sym = enc4b5b(s_txd);
            end
        end
    end

    // Sampling falls on the generated rising edge; the MAC is never stalled,
    // and words are dropped when the FIFO is full, which tx_fifo_ready reports.
    always @(posedge mclk) begin
        if (srst) begin
            wr_sym    <= {`PMX_SYM_W{1'b0}};
            wr_valid  <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            wr_valid <= 1'b0;
            if (rise_evt) begin
                tx_active <= s_en;
                if (s_en) begin
                    wr_sym   <= next_sym;
                    wr_valid <= 1'b1;
                end
            end
        end
    end

    pmx_fifo #(
        .WIDTH (`PMX_SYM_W),
        .DEPTH (`PMX_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_data   (wr_sym),
        .in_valid  (wr_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (line_sym),
        .out_valid (line_valid),
        .out_ready (line_ready)
    );

    assign tx_fifo_ready = fifo_in_ready;

    // ****************************************
    // Receive valid, data and error
    // ****************************************
    // Limitation: rx_clk comes from the local divider, not from line timing
    reg                  pend_ssd;
    reg                  pend_end;
    reg                  pend_err;
    reg                  pend_fc;
    reg                  in_frame;
    reg                  next_frame;
    reg [`PMX_NIB_W-1:0] rx_hold;

    // Events between receive clock updates are held; a new event wins over
    // the clear done at the update.
    always @(posedge mclk) begin
        if (srst) begin
            pend_ssd <= 1'b0;
            pend_end <= 1'b0;
            pend_err <= 1'b0;
            pend_fc  <= 1'b0;
            rx_hold  <= 4'h0;
        end else begin
            pend_ssd <= rx_ssd_det || (pend_ssd && !fall_evt);
            pend_end <= rx_esd_det || (pend_end && !fall_evt);
            pend_err <= rx_sig_err || (pend_err && !fall_evt);
            pend_fc  <= rx_false_carrier || (pend_fc && !fall_evt);
            rx_hold  <= rx_nib_in;
        end
    end

    always @* begin
        next_frame = in_frame;
        if (pend_end || pend_err) begin
            next_frame = 1'b0;
        end else if (pend_ssd) begin
            next_frame = 1'b1;
        end
    end

    // rxd, rx_dv and rx_er move at the falling update so they are stable at the rise; rx_oe_n follows every cycle
    always @(posedge mclk) begin
        if (srst) begin
            in_frame <= 1'b0;
            rxd      <= 4'h0;
            rx_dv    <= 1'b0;
            rx_er    <= 1'b0;
            rx_oe_n  <= 1'b1;
        end else begin
            rx_oe_n <= s_tri;
            if (fall_evt) begin
                in_frame <= next_frame;
                rx_dv    <= next_frame;
                rxd      <= next_frame ? rx_hold : 4'h0;
                rx_er    <= speed_100 &&
                            ((in_frame && pend_err) || (!in_frame && pend_fc));
            end
        end
    end
endmodule // pmx_mii

// ===== design/pmx_mii_regs.vh
// Constants for the MII transmit, receive-error and tri-state path
`ifndef PMX_MII_REGS_VH
`define PMX_MII_REGS_VH

// Rates in kHz; half periods of the MII clocks are derived in mclk cycles
`define PMX_MCLK_KHZ      100000
`define PMX_FAST_KHZ      25000
`define PMX_SLOW_KHZ      2500
`define PMX_HALF_FAST     ((`PMX_MCLK_KHZ / `PMX_FAST_KHZ) / 2)
`define PMX_HALF_SLOW     ((`PMX_MCLK_KHZ / `PMX_SLOW_KHZ) / 2)
`define PMX_DIV_W         5

// Symbol codes and widths
`define PMX_SYM_W         5
`define PMX_NIB_W         4
`define PMX_HALT_SYM      5'h04
`define PMX_TEST_SYM      5'h1F
`define PMX_FIFO_DEPTH    16

`endif

// ===== verif/pmx_mac_model.sv
// Behavioural MAC driving the transmit side of the MII
`timescale 1ns/10ps
module pmx_mac_model (
    input  wire logic       tx_clk,
    output logic            tx_en,
    output logic            tx_er,
    output logic [3:0]      txd
);
    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd   = 4'h0;
    end
    // nibble held a period
    // Driven just after the rise, so the PHY sees a whole period of setup
    task automatic send(input logic [3:0] nib, input logic err);
        @(posedge tx_clk);
        #1;
        tx_en = 1'b1;
        tx_er = err;
        txd   = nib;
    endtask
    // Released data shows the inverse so a stale nibble cannot pass
    task automatic stop();
        @(posedge tx_clk);
        #1;
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd   = ~txd;
    endtask
endmodule // pmx_mac_model

// ===== verif/pmx_mii_chk.sv
// Assertion checker for the MII PHY-side path
`timescale 1ns/10ps
module pmx_mii_chk (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       speed_100,
    input wire logic       tx_clk,
    input wire logic       tx_active,
    input wire logic       rx_ssd_det,
    input wire logic       rx_esd_det,
    input wire logic       rx_sig_err,
    input wire logic       rx_false_carrier,
    input wire logic       rx_tristate_request,
    input wire logic       rx_clk,
    input wire logic [3:0] rxd,
    input wire logic       rx_dv,
    input wire logic       rx_er,
    input wire logic       rx_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ****************************************
    // Helper state
    // ****************************************
    logic [4:0] hi_cnt;
    logic [1:0] age;
    logic       ssd_seen;
    logic       err_seen;
    // An event on the update edge itself may count for the next period
    always @(posedge mclk) begin
        if (srst) begin
            hi_cnt   <= 5'h00;
            age      <= 2'h0;
            ssd_seen <= 1'b0;
            err_seen <= 1'b0;
        end else begin
            hi_cnt   <= tx_clk ? hi_cnt + 5'h01 : 5'h00;
            age      <= (age == 2'h3) ? age : age + 2'h1;
            ssd_seen <= rx_ssd_det | (ssd_seen & !($fell(rx_clk) & !$past(rx_ssd_det)));
            err_seen <= rx_sig_err | rx_false_carrier
                        | (err_seen & !($fell(rx_clk) & !$past(rx_sig_err | rx_false_carrier)));
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    sequence s_dv_drop;
        ##[1:42] !rx_dv;
    endsequence
    a_tx_high_time: assert property (
        $fell(tx_clk) |-> hi_cnt == (speed_100 ? 5'h02 : 5'h14)) else $error("tx_clk high time");
    a_rx_clk_phase: assert property (
        rx_clk == tx_clk) else $error("rx_clk out of phase");
    a_rxer_slow_off: assert property (
        !speed_100 |-> !rx_er) else $error("rx_er at slow rate");
    a_rx_out_sync: assert property (
        !$fell(rx_clk) |-> $stable({rxd, rx_dv, rx_er})) else $error("receive output moved");
    a_oe_follow_req: assert property (
        age == 2'h3 |-> rx_oe_n == $past(rx_tristate_request, 3)) else $error("rx_oe_n lag");
    a_dv_cause: assert property (
        $rose(rx_dv) |-> ssd_seen) else $error("rx_dv rose without start");
    a_er_cause: assert property (
        $rose(rx_er) |-> err_seen && speed_100) else $error("rx_er rose without cause");
    a_dv_end: assert property (
        rx_dv && (rx_esd_det || rx_sig_err) |-> s_dv_drop) else $error("rx_dv did not drop");
    a_active_on_rise: assert property (
        !$rose(tx_clk) |-> $stable(tx_active)) else $error("tx_active off the rise");
endmodule // pmx_mii_chk

bind pmx_mii pmx_mii_chk u_chk (.mclk, .srst, .speed_100, .tx_clk, .tx_active, .rx_ssd_det,
    .rx_esd_det, .rx_sig_err, .rx_false_carrier, .rx_tristate_request, .rx_clk, .rxd, .rx_dv,
    .rx_er, .rx_oe_n);

// ===== verif/pmx_mii_tb.sv
// Self-checking bench for the MII PHY-side path
`timescale 1ns/10ps
module pmx_mii_tb;
    localparam logic [4:0] test_sym = 5'h19; // Not a data code
    localparam logic [4:0] enc [0:15] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic       mclk, srst, speed_100, err_code_test, tx_clk, tx_en, tx_er, tx_active;
    logic       tx_fifo_ready, line_valid, line_ready, rx_ssd_det, rx_esd_det, rx_sig_err;
    logic       rx_false_carrier, rx_tristate_request, rx_clk, rx_dv, rx_er, rx_oe_n, full_seen;
    logic [3:0] txd, rx_nib_in, rxd;
    logic [4:0] line_sym;
    logic [4:0] got [$];
    int         err_total, n_tests;

    pmx_mii #(.TEST_SYM(test_sym)) dut (.mclk, .srst, .speed_100, .err_code_test, .tx_clk,
        .tx_en, .tx_er, .txd, .tx_active, .tx_fifo_ready, .line_sym, .line_valid, .line_ready,
        .rx_nib_in, .rx_ssd_det, .rx_esd_det, .rx_sig_err, .rx_false_carrier,
        .rx_tristate_request, .rx_clk, .rxd, .rx_dv, .rx_er, .rx_oe_n);
    pmx_mac_model mac (.tx_clk, .tx_en, .tx_er, .txd);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (line_valid && line_ready) got.push_back(line_sym);
        if (!tx_fifo_ready) full_seen = 1'b1;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset(input logic s);
        srst = 1'b1;
        speed_100 = s;
        tick(8);
        check("reset line_valid", line_valid, 0);
        check("reset rx_oe_n", rx_oe_n, 1);
        srst = 1'b0;
        tick(3);
    endtask
    // Counts mclk cycles to the next falling edge of the chosen clock
    task automatic wait_fall(input logic use_tx, output int c);
        logic p;
        p = use_tx ? tx_clk : rx_clk;
        for (c = 1; c <= 60; c++) begin
            tick(1);
            if (p && !(use_tx ? tx_clk : rx_clk)) return;
            p = use_tx ? tx_clk : rx_clk;
        end
        err_total++;
        results();
    endtask
    task automatic pulse(input int k);
        {rx_ssd_det, rx_esd_det, rx_sig_err, rx_false_carrier} = 4'h8 >> k;
        tick(1);
        {rx_ssd_det, rx_esd_det, rx_sig_err, rx_false_carrier} = 4'h0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_clk(input logic s);
        int c;
        do_reset(s);
        wait_fall(1, c);
        wait_fall(1, c);
        check("tx_clk period", c, s ? 4 : 40);
        wait_fall(0, c);
        wait_fall(0, c);
        check("rx_clk period", c, s ? 4 : 40);
    endtask
    task automatic t_tx(input logic s, input logic t);
        int i;
        logic [4:0] e;
        do_reset(s);
        err_code_test = t;
        got.delete();
        for (i = 0; i < 16; i++) mac.send(i[3:0], i == 5 || i == 10);
        mac.stop();
        tick(100);
        check("word count", 8'(got.size()), 16);
        check("tx_active idle", tx_active, 0);
        for (i = 0; i < 16; i++) begin
            e = (s && (i == 5 || i == 10)) ? (t ? test_sym : 5'h04) : (s ? enc[i] : {1'b0, i[3:0]});
            check("line word", got[i], e);
        end
    endtask
    task automatic t_fifo();
        int i;
        do_reset(1);
        got.delete();
        full_seen = 1'b0;
        line_ready = 1'b0;
        for (i = 0; i < 20; i++) mac.send(i[3:0], 1'b0);
        mac.stop();
        // Line side stalls every other cycle while draining
        for (i = 0; i < 80; i++) begin
            line_ready = i[0];
            tick(1);
        end
        line_ready = 1'b1;
        check("fifo refused", full_seen, 1);
        check("fifo ready again", tx_fifo_ready, 1);
        check("kept words", got.size() inside {[16:18]}, 1);
        for (i = 0; i < got.size(); i++) check("fifo order", got[i], enc[i % 16]);
    endtask
    task automatic t_rx(input logic s);
        int c;
        do_reset(s);
        rx_nib_in = 4'hA;
        pulse(0);
        wait_fall(0, c);
        check("rx_dv start", rx_dv, 1);
        check("rxd", rxd, 4'hA);
        pulse(1);
        wait_fall(0, c);
        check("rx_dv end", rx_dv, 0);
        check("rx_er end", rx_er, 0);
        pulse(0);
        wait_fall(0, c);
        pulse(2);
        wait_fall(0, c);
        check("rx_dv error", rx_dv, 0);
        check("rx_er error", rx_er, s);
        check("rxd idle", rxd, 0);
        wait_fall(0, c);
        check("rx_er clear", rx_er, 0);
        pulse(3);
        wait_fall(0, c);
        check("rx_er carrier", rx_er, s);
    endtask
    task automatic t_tri();
        rx_tristate_request = 1'b1;
        tick(4);
        check("rx_oe_n high", rx_oe_n, 1);
        rx_tristate_request = 1'b0;
        tick(4);
        check("rx_oe_n low", rx_oe_n, 0);
    endtask
    initial begin
        err_total = 0;
        n_tests = 0;
        {srst, speed_100, line_ready} = 3'h7;
        {err_code_test, rx_ssd_det, rx_esd_det, rx_sig_err, rx_false_carrier} = 5'h00;
        {rx_tristate_request, full_seen, rx_nib_in} = 6'h00;
        t_clk(1);
        t_clk(0);
        t_tx(1, 0);
        t_tx(1, 1);
        t_tx(0, 0);
        t_tx(0, 1);
        t_fifo();
        t_rx(1);
        t_rx(0);
        t_tri();
        results();
    end
    initial begin
        #900000;
        err_total++;
        results();
    end
endmodule // pmx_mii_tb
